/* hw/ces_pkg.sv */
/*
 * Shared constants and types for the CPU exception sequencer:
 * vector numbers, status word layout, source ranking and states.
 * Assumes a 32-bit address space and word-wide vector entries.
 */
package ces_pkg;

    localparam int N_SRC = 11;
    localparam logic [7:0] VEC_POR_PC = 8'h00;
    localparam logic [7:0] VEC_MR_PC = 8'h02;
    localparam logic [7:0] VEC_GILL = 8'h04;
    localparam logic [7:0] VEC_SILL = 8'h06;
    localparam logic [7:0] VEC_CAE = 8'h09;
    localparam logic [7:0] VEC_DAE = 8'h0A;
    localparam logic [7:0] VEC_NMI = 8'h0B;
    localparam logic [7:0] VEC_UBRK = 8'h0C;
    localparam logic [7:0] VEC_IRQ0 = 8'h40;
    localparam logic [31:0] BASE_RESET = 32'h0000_0000;
    localparam logic [31:0] WORD_BYTES = 32'h0000_0004;
    localparam logic [3:0] IMASK_ALL = 4'hF;
    localparam logic [3:0] NMI_LEVEL = 4'hF;
    localparam logic [3:0] UBRK_LEVEL = 4'hF;
    localparam int IMASK_LSB = 4;

    // Index order is the service order, lowest index first
    typedef enum logic [3:0] {
        SRC_POR = 4'h0, SRC_MR = 4'h1, SRC_CAE = 4'h2, SRC_DAE = 4'h3,
        SRC_NMI = 4'h4, SRC_UBRK = 4'h5, SRC_IRQ = 4'h6, SRC_PER = 4'h7,
        SRC_TRAP = 4'h8, SRC_GILL = 4'h9, SRC_SILL = 4'hA
    } ces_src_t;

    typedef enum logic [3:0] {
        CLS_PLAIN = 4'h0, CLS_JMP = 4'h1, CLS_JSR = 4'h2, CLS_BRA = 4'h3,
        CLS_BSR = 4'h4, CLS_RTS = 4'h5, CLS_RTE = 4'h6, CLS_BT = 4'h7,
        CLS_BF = 4'h8, CLS_BTS = 4'h9, CLS_BFS = 4'hA, CLS_BSRF = 4'hB,
        CLS_BRAF = 4'hC, CLS_TRAP = 4'hD, CLS_UNDEF = 4'hE
    } ces_cls_t;

    // Gray codes along the stacking path
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0, ST_WSR = 3'h4, ST_WPC = 3'h5, ST_RVEC = 3'h1,
        ST_RPC = 3'h2, ST_RSP = 3'h6
    } ces_st_t;

endpackage

/* hw/ces_sync.sv */
/*
 * Two-flop synchroniser for one asynchronous level.
 * Assumes the input is held for at least two clock periods.
 */
`timescale 1ns/1ps
module ces_sync (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic async_in,
    output logic sync_q
);
    logic meta_q;

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
        end else begin
            meta_q <= async_in;
            sync_q <= meta_q;
        end
    end
endmodule

/* hw/ces_arbiter.sv */
/*
 * Fixed-rank picker over the pending exception sources.
 * Assumes lower index means higher rank; purely combinational.
 */
`timescale 1ns/1ps
module ces_arbiter
    import ces_pkg::*;
(
    input wire logic [N_SRC-1:0] pend,
    output logic any,
    output ces_src_t top
);
    always_comb begin
        any = |pend;
        top = SRC_SILL;
        // RULE1 fixed rank pick
        // Walk from lowest rank so the highest one wins
        for (int i = N_SRC - 1; i >= 0; i--) begin
            if (pend[i]) begin
                top = ces_src_t'(i[3:0]);
            end
        end
    end
endmodule

/* hw/ces_seq.sv */
/*
 * Exception sequencer of the CPU: ranks pending sources, runs reset
 * vector fetch or stacking plus vector fetch, and hands new PC, SP and
 * status word to the pipeline. Assumes the pipeline stalls decode while
 * seq_busy_q is high and a word memory port answers with mem_ack.
 */
// Notes on behaviour
// RULE1 - Serve pending sources in fixed rank, power-on reset highest, slot illegal lowest.
// RULE2 - Power-on reset on rising reset pin or watchdog overflow of power-on type.
// RULE3 - Manual reset only from watchdog overflow of manual type, never the pin.
// RULE4 - Address errors and interrupts caught at decode, taken after current instruction completes.
// RULE5 - Software trap starts when the trap instruction executes.
// RULE6 - Undefined opcode outside a delay slot raises general illegal.
// RULE7 - Undefined or PC-writing opcode in a delay slot raises slot illegal.
// RULE8 - Branches, calls, returns and trap count as PC-writing; ten kinds are delayed.
// RULE9 - Power-on reset reads PC from word 0 and SP from word 4.
// RULE10 - Manual reset reads PC from word 8 and SP from word 12.
// RULE11 - Reset clears vector base and sets all four mask bits.
// RULE12 - After reset, fetch starts at the PC read from the table.
// RULE13 - Other exceptions push status word and PC on the stack register.
// RULE14 - Interrupts copy their level into the mask field.
// RULE15 - Address errors and instruction exceptions keep the mask field.
// RULE16 - After stacking, read handler address and continue there.
// RULE17 - Vector address is base plus four times number; resets use no base.
// RULE18 - Each source has its own vector number.
// RULE19 - Stack drops by four for status, by four again for PC.
// RULE20 - One exception per decision; others wait until the handler address is fetched. Taking a reset clears all other pending sources instead.
`timescale 1ns/1ps
module ces_seq
    import ces_pkg::*;
#(
    parameter int IRQ_N = 4
)
(
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic external_reset_pin_n,
    input wire logic wdog_ovf,
    input wire logic wdog_manual_sel,
    input wire logic cpu_addr_err,
    input wire logic dma_addr_err,
    input wire logic nmi_req,
    input wire logic ubrk_req,
    input wire logic [IRQ_N-1:0] irq_req,
    input wire logic [3:0] irq_level,
    input wire logic per_req,
    input wire logic [3:0] per_level,
    input wire logic [7:0] per_vec,
    input wire logic dec_valid,
    input wire ces_cls_t dec_cls,
    input wire logic exe_trap,
    input wire logic [7:0] trap_vec,
    input wire logic insn_done,
    input wire logic [31:0] cur_stat,
    input wire logic [31:0] cur_pc,
    input wire logic [31:0] stack_gpr,
    input wire logic base_wr,
    input wire logic [31:0] base_wdata,
    input wire logic mem_ack,
    input wire logic [31:0] mem_rdata,
    output logic mem_req_q,
    output logic mem_we_q,
    output logic [31:0] mem_addr_q,
    output logic [31:0] mem_wdata_q,
    output logic [31:0] vector_base_reg_q,
    output logic seq_busy_q,
    output logic exc_taken_q,
    output ces_src_t exc_src_q,
    output logic pc_load_q,
    output logic [31:0] new_pc_q,
    output logic sp_load_q,
    output logic [31:0] new_sp_q,
    output logic stat_load_q,
    output logic [31:0] status_word_q
);
    generate
        if (IRQ_N < 1 || IRQ_N > 4) begin : g_bad_irq
            $error("IRQ_N must be 1 to 4");
        end
    endgenerate

    function automatic logic [31:0] vec_addr(input logic [31:0] base, input logic [7:0] num);
        vec_addr = base + {22'h0, num, 2'b00};
    endfunction

    function automatic logic is_delayed(input ces_cls_t c);
        is_delayed = c inside {CLS_JMP, CLS_JSR, CLS_BRA, CLS_BSR, CLS_RTS, CLS_RTE,
                               CLS_BTS, CLS_BFS, CLS_BSRF, CLS_BRAF};
    endfunction

    function automatic logic writes_pc(input ces_cls_t c);
        writes_pc = is_delayed(c) || c inside {CLS_BT, CLS_BF, CLS_TRAP};
    endfunction

    function automatic logic waits_done(input ces_src_t s);
        waits_done = s inside {SRC_CAE, SRC_DAE, SRC_NMI, SRC_UBRK, SRC_IRQ, SRC_PER};
    endfunction

    function automatic logic [31:0] with_mask(input logic [31:0] word, input logic [3:0] m);
        with_mask = word;
        with_mask[IMASK_LSB +: 4] = m;
    endfunction

    ces_st_t state_q, state_d;
    logic pin_sync, pin_prev_q, pin_rise;
    logic slot_q;
    logic [N_SRC-1:0] pend_q, set_v;
    logic top_any, take;
    ces_src_t top;
    logic [7:0] irq_vec_q, per_vec_q, trap_vec_q, vec_q, vec_d;
    logic [3:0] irq_lvl_q, per_lvl_q, lvl_q, lvl_d;
    logic int_q, int_d;
    logic [31:0] sp_q, stat_q, pc_q, rst_pc_q;

    ces_sync u_pin_sync (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .async_in(external_reset_pin_n),
        .sync_q(pin_sync)
    );

    ces_arbiter u_arb (
        .pend(pend_q),
        .any(top_any),
        .top(top)
    );

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            pin_prev_q <= 1'b0;
        end else begin
            pin_prev_q <= pin_sync;
        end
    end
    // RULE2 pin rising edge
    assign pin_rise = pin_sync && !pin_prev_q;

    // RULE6 RULE7 RULE8 delay slot tracking
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            slot_q <= 1'b0;
        end else if (pc_load_q) begin
            slot_q <= 1'b0;
        end else if (dec_valid) begin
            slot_q <= is_delayed(dec_cls);
        end
    end

    always_comb begin
        set_v = '0;
        // RULE2 RULE3 reset sources
        set_v[SRC_POR] = pin_rise || (wdog_ovf && !wdog_manual_sel);
        set_v[SRC_MR] = wdog_ovf && wdog_manual_sel;
        // RULE4 sampled at decode
        set_v[SRC_CAE] = dec_valid && cpu_addr_err;
        set_v[SRC_DAE] = dec_valid && dma_addr_err;
        set_v[SRC_NMI] = dec_valid && nmi_req;
        set_v[SRC_UBRK] = dec_valid && ubrk_req;
        set_v[SRC_IRQ] = dec_valid && (|irq_req);
        set_v[SRC_PER] = dec_valid && per_req;
        // RULE5 trap at execution
        set_v[SRC_TRAP] = exe_trap;
        // RULE6 RULE7 illegal opcode split
        set_v[SRC_GILL] = dec_valid && !slot_q && dec_cls == CLS_UNDEF;
        set_v[SRC_SILL] = dec_valid && slot_q && (dec_cls == CLS_UNDEF || writes_pc(dec_cls));
    end

    // RULE4 RULE20 one decision, addr and int wait for completion
    assign take = state_q == ST_IDLE && top_any && (!waits_done(top) || insn_done);

    // Set beats clear so an event in the acceptance cycle survives
    generate
        for (genvar i = 0; i < N_SRC; i++) begin : g_pend
            always_ff @(posedge sys_clk or negedge rst_b) begin
                if (!rst_b) begin
                    pend_q[i] <= 1'b0;
                end else begin
                    pend_q[i] <= set_v[i] || (pend_q[i] && !(take && (top == 4'(i) || top == SRC_POR
                                 || top == SRC_MR)));
                end
            end
        end
    endgenerate

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            irq_vec_q <= 8'h00;
            irq_lvl_q <= 4'h0;
            per_vec_q <= 8'h00;
            per_lvl_q <= 4'h0;
            trap_vec_q <= 8'h00;
        end else begin
            if (set_v[SRC_IRQ]) begin
                irq_lvl_q <= irq_level;
                irq_vec_q <= VEC_IRQ0;
                for (int k = IRQ_N - 1; k >= 0; k--) begin
                    if (irq_req[k]) begin
                        irq_vec_q <= VEC_IRQ0 + 8'(k);
                    end
                end
            end
            if (set_v[SRC_PER]) begin
                per_vec_q <= per_vec;
                per_lvl_q <= per_level;
            end
            if (set_v[SRC_TRAP]) begin
                trap_vec_q <= trap_vec;
            end
        end
    end

    // RULE18 vector per source, RULE14 RULE15 mask source
    always_comb begin
        vec_d = VEC_GILL;
        lvl_d = 4'h0;
        int_d = 1'b0;
        unique case (top)
            SRC_POR: vec_d = VEC_POR_PC;
            SRC_MR: vec_d = VEC_MR_PC;
            SRC_CAE: vec_d = VEC_CAE;
            SRC_DAE: vec_d = VEC_DAE;
            SRC_NMI: begin
                vec_d = VEC_NMI;
                lvl_d = NMI_LEVEL;
                int_d = 1'b1;
            end
            SRC_UBRK: begin
                vec_d = VEC_UBRK;
                lvl_d = UBRK_LEVEL;
                int_d = 1'b1;
            end
            SRC_IRQ: begin
                vec_d = irq_vec_q;
                lvl_d = irq_lvl_q;
                int_d = 1'b1;
            end
            SRC_PER: begin
                vec_d = per_vec_q;
                lvl_d = per_lvl_q;
                int_d = 1'b1;
            end
            SRC_TRAP: vec_d = trap_vec_q;
            SRC_GILL: vec_d = VEC_GILL;
            SRC_SILL: vec_d = VEC_SILL;
            default: vec_d = VEC_GILL;
        endcase
    end

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            ST_IDLE: begin
                if (take) begin
                    state_d = (top == SRC_POR || top == SRC_MR) ? ST_RPC : ST_WSR;
                end
            end
            ST_RPC: if (mem_ack) state_d = ST_RSP;
            ST_RSP: if (mem_ack) state_d = ST_IDLE;
            ST_WSR: if (mem_ack) state_d = ST_WPC;
            ST_WPC: if (mem_ack) state_d = ST_RVEC;
            ST_RVEC: if (mem_ack) state_d = ST_IDLE;
            default: state_d = ST_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            state_q <= ST_IDLE;
            seq_busy_q <= 1'b0;
        end else begin
            state_q <= state_d;
            seq_busy_q <= state_d != ST_IDLE;
        end
    end

    // Context captured at acceptance, stable for the whole sequence
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            vec_q <= 8'h00;
            lvl_q <= 4'h0;
            int_q <= 1'b0;
            sp_q <= 32'h0000_0000;
            stat_q <= 32'h0000_0000;
            pc_q <= 32'h0000_0000;
            exc_taken_q <= 1'b0;
            exc_src_q <= SRC_POR;
        end else begin
            exc_taken_q <= take;
            if (take) begin
                vec_q <= vec_d;
                lvl_q <= lvl_d;
                int_q <= int_d;
                sp_q <= stack_gpr;
                stat_q <= cur_stat;
                pc_q <= cur_pc;
                exc_src_q <= top;
            end
        end
    end

    // Memory port: request held until acknowledged, then next address
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            mem_req_q <= 1'b0;
            mem_we_q <= 1'b0;
            mem_addr_q <= 32'h0000_0000;
            mem_wdata_q <= 32'h0000_0000;
        end else begin
            mem_req_q <= state_d != ST_IDLE;
            mem_we_q <= state_d == ST_WSR || state_d == ST_WPC;
            if (state_d != state_q) begin
                unique case (state_d)
                    // RULE9 RULE10 RULE17 reset vectors with no base
                    ST_RPC: mem_addr_q <= vec_addr(BASE_RESET, vec_d);
                    ST_RSP: mem_addr_q <= vec_addr(BASE_RESET, vec_q + 8'h01);
                    // RULE13 RULE19 status word first, below old stack top
                    ST_WSR: begin
                        mem_addr_q <= stack_gpr - WORD_BYTES;
                        mem_wdata_q <= cur_stat;
                    end
                    ST_WPC: begin
                        mem_addr_q <= sp_q - WORD_BYTES - WORD_BYTES;
                        mem_wdata_q <= pc_q;
                    end
                    // RULE16 RULE17 handler address from base plus offset
                    ST_RVEC: mem_addr_q <= vec_addr(vector_base_reg_q, vec_q);
                    default: mem_addr_q <= mem_addr_q;
                endcase
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_pc_q <= 32'h0000_0000;
        end else if (state_q == ST_RPC && mem_ack) begin
            rst_pc_q <= mem_rdata;
        end
    end

    // Results to the pipeline, one-cycle load strobes
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            pc_load_q <= 1'b0;
            sp_load_q <= 1'b0;
            stat_load_q <= 1'b0;
            new_pc_q <= 32'h0000_0000;
            new_sp_q <= 32'h0000_0000;
            status_word_q <= 32'h0000_0000;
        end else begin
            pc_load_q <= 1'b0;
            sp_load_q <= 1'b0;
            stat_load_q <= 1'b0;
            if (state_q == ST_RSP && mem_ack) begin
                // RULE12 fetch at table PC, RULE11 mask all ones
                pc_load_q <= 1'b1;
                sp_load_q <= 1'b1;
                stat_load_q <= 1'b1;
                new_pc_q <= rst_pc_q;
                new_sp_q <= mem_rdata;
                status_word_q <= with_mask(stat_q, IMASK_ALL);
            end else if (state_q == ST_RVEC && mem_ack) begin
                pc_load_q <= 1'b1;
                sp_load_q <= 1'b1;
                stat_load_q <= 1'b1;
                new_pc_q <= mem_rdata;
                new_sp_q <= sp_q - WORD_BYTES - WORD_BYTES;
                // RULE14 RULE15 mask only for interrupts
                status_word_q <= int_q ? with_mask(stat_q, lvl_q) : stat_q;
            end
        end
    end

    // RULE11 base cleared by either reset
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            vector_base_reg_q <= BASE_RESET;
        end else if (state_q == ST_RSP && mem_ack) begin
            vector_base_reg_q <= BASE_RESET;
        end else if (base_wr) begin
            vector_base_reg_q <= base_wdata;
        end
    end

    logic [N_SRC-1:0] higher_mask;
    assign higher_mask = N_SRC'((16'h0001 << exc_src_q) - 16'h0001);

    sequence s_push;
        state_q == ST_WSR && mem_ack ##1 state_q == ST_WPC;
    endsequence

    sequence s_rst_done;
        state_q == ST_RSP && mem_ack;
    endsequence

    a_rank_order: assert property (@(posedge sys_clk) disable iff (!rst_b) // RULE1
        exc_taken_q |-> ($past(pend_q) & higher_mask) == '0)
        else $error("higher ranked source was passed over");

    a_por_pin_rise: assert property (@(posedge sys_clk) disable iff (!rst_b) // RULE2
        pin_rise && state_q == ST_IDLE |=> pend_q[SRC_POR])
        else $error("pin rise did not raise power-on reset");

    a_mr_wdog_only: assert property (@(posedge sys_clk) disable iff (!rst_b) // RULE3
        $rose(pend_q[SRC_MR]) |-> $past(wdog_ovf) && $past(wdog_manual_sel))
        else $error("manual reset without manual watchdog overflow");

    a_wait_completion: assert property (@(posedge sys_clk) disable iff (!rst_b) // RULE4
        exc_taken_q && waits_done(exc_src_q) |-> $past(insn_done))
        else $error("address error or interrupt taken mid-instruction");

    a_trap_on_exec: assert property (@(posedge sys_clk) disable iff (!rst_b) // RULE5
        $rose(pend_q[SRC_TRAP]) |-> $past(exe_trap))
        else $error("trap raised without execution");

    a_illegal_split: assert property (@(posedge sys_clk) disable iff (!rst_b) // RULE7
        dec_valid && slot_q && dec_cls == CLS_BT |=> pend_q[SRC_SILL] && !$rose(pend_q[SRC_GILL]))
        else $error("branch in delay slot not flagged as slot illegal");

    a_reset_vectors: assert property (@(posedge sys_clk) disable iff (!rst_b) // RULE10
        state_q == ST_RPC && exc_src_q == SRC_MR |-> mem_addr_q == 32'h0000_0008 && !mem_we_q)
        else $error("manual reset PC vector address wrong");

    a_stack_pair: assert property (@(posedge sys_clk) disable iff (!rst_b) // RULE19
        s_push |-> mem_we_q && mem_addr_q == sp_q - 32'h0000_0008 && mem_wdata_q == pc_q)
        else $error("PC not pushed eight below the old stack top");

    a_reset_state: assert property (@(posedge sys_clk) disable iff (!rst_b) // RULE11
        s_rst_done |=> vector_base_reg_q == 32'h0000_0000 && status_word_q[7:4] == 4'hF && pc_load_q)
        else $error("reset left base or mask wrong");

    a_mask_kept: assert property (@(posedge sys_clk) disable iff (!rst_b) // RULE15
        state_q == ST_RVEC && mem_ack && !int_q |=> status_word_q == stat_q && new_pc_q == $past(mem_rdata))
        else $error("non-interrupt exception changed the mask");

    a_single_accept: assert property (@(posedge sys_clk) disable iff (!rst_b) // RULE20
        exc_taken_q |-> !$past(exc_taken_q) ##1 !exc_taken_q [*2])
        else $error("second exception accepted during a sequence");

endmodule

/* testbench/ces_mem_model.sv */
/*
 * Word memory standing behind the sequencer's memory port.
 * Assumes requests hold until acked; slow mode stalls each word.
 */
`timescale 1ns/1ps
module ces_mem_model (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic mem_req_q,
    input wire logic [31:0] mem_addr_q,
    input wire logic slow,
    output logic mem_ack,
    output logic [31:0] mem_rdata
);
    logic [1:0] wait_q;
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            wait_q <= 2'h0;
        end else if (mem_req_q && !mem_ack) begin
            wait_q <= wait_q + 2'h1;
        end else begin
            wait_q <= 2'h0;
        end
    end
    // Slow mode acks on the third cycle of each word
    assign mem_ack = mem_req_q && (!slow || wait_q == 2'h2);
    // Inverse outside ack, so a stale sample shows up
    assign mem_rdata = mem_ack ? (32'h5A00_0000 ^ mem_addr_q) : ~(32'h5A00_0000 ^ mem_addr_q);
endmodule

/* testbench/tb.sv */
/*
 * Self-checking bench of the exception sequencer.
 * Assumes the memory model answers the memory port.
 */
`timescale 1ns/1ps
module tb
    import ces_pkg::*;
;
    logic sys_clk = 0, rst_b = 0, pin = 1, wdog_ovf = 0, wdog_man = 0, cae = 0, dae = 0, nmi = 0, ubrk = 0;
    logic per = 0, dv = 0, trap = 0, done = 0, base_wr = 0, slow = 0;
    logic [3:0] irq = 4'h0, irq_lvl = 4'h3, per_lvl = 4'h5;
    logic [7:0] per_vec = 8'h50, trap_vec = 8'h21;
    ces_cls_t cls = CLS_PLAIN;
    // Nonzero mask field so a wrongly rewritten mask shows
    logic [31:0] base_d = 32'h0000_2000, st0 = 32'h0000_0371, pc0 = 32'h0000_0A0C, sp0 = 32'h0000_8000;
    logic mem_req, mem_we, mem_ack, pc_ld, sp_ld, st_ld, busy, taken;
    logic [31:0] addr, wdata, rdata, vbase, npc, nsp, sw;
    ces_src_t src;
    int n_mismatch = 0, n_tests = 0, na = 0, cyc = 0;
    logic [31:0] la [4];
    logic [31:0] ld [4];
    logic lw [4];

    ces_seq DUT (.sys_clk(sys_clk), .rst_b(rst_b), .external_reset_pin_n(pin), .wdog_ovf(wdog_ovf),
        .wdog_manual_sel(wdog_man), .cpu_addr_err(cae), .dma_addr_err(dae), .nmi_req(nmi), .ubrk_req(ubrk),
        .irq_req(irq), .irq_level(irq_lvl), .per_req(per), .per_level(per_lvl), .per_vec(per_vec),
        .dec_valid(dv), .dec_cls(cls), .exe_trap(trap), .trap_vec(trap_vec), .insn_done(done),
        .cur_stat(st0), .cur_pc(pc0), .stack_gpr(sp0), .base_wr(base_wr), .base_wdata(base_d), .mem_ack(mem_ack),
        .mem_rdata(rdata), .mem_req_q(mem_req), .mem_we_q(mem_we), .mem_addr_q(addr), .mem_wdata_q(wdata),
        .vector_base_reg_q(vbase), .seq_busy_q(busy), .exc_taken_q(taken), .exc_src_q(src), .pc_load_q(pc_ld),
        .new_pc_q(npc), .sp_load_q(sp_ld), .new_sp_q(nsp), .stat_load_q(st_ld), .status_word_q(sw));

    ces_mem_model mem (.sys_clk(sys_clk), .rst_b(rst_b), .mem_req_q(mem_req), .mem_addr_q(addr),
        .slow(slow), .mem_ack(mem_ack), .mem_rdata(rdata));

    initial begin
        forever #5 sys_clk = ~sys_clk;
    end

    // Log of accepted memory words
    always @(posedge sys_clk) begin
        if (mem_req && mem_ack && na < 4) begin
            la[na] = addr;
            lw[na] = mem_we;
            ld[na] = mem_we ? wdata : rdata;
            na++;
        end
    end

    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 5000) begin
            n_mismatch++;
            end_sim();
        end
    end

    function automatic logic [31:0] rd_word(input logic [31:0] a);
        return 32'h5A00_0000 ^ a;
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic end_sim;
        $display("tests=%0d mismatches=%0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // Waits for one whole sequence and judges its bus traffic and loads
    task automatic do_exc(input ces_src_t s, input logic [31:0] va, input logic rk, input logic [3:0] m);
        int i;
        #1;
        na = 0;
        for (i = 0; i < 40 && taken !== 1'b1; i++) begin
            @(posedge sys_clk);
            #1;
        end
        chk(32'(src), 32'(s));
        for (i = 0; i < 60 && pc_ld !== 1'b1; i++) begin
            @(posedge sys_clk);
            #1;
        end
        chk({30'h0, sp_ld, st_ld}, 32'h3);
        chk(npc, rd_word(va));
        if (rk) begin
            chk(32'(na), 32'h2);
            chk(la[0], va);
            chk(la[1], va + 32'h4);
            chk(nsp, rd_word(va + 32'h4));
            chk(vbase, 32'h0);
            chk(32'(sw[7:4]), 32'hF);
        end else begin
            chk(32'(na), 32'h3);
            chk({29'h0, lw[0], lw[1], lw[2]}, 32'h6);
            chk(la[0], sp0 - 32'h4);
            chk(ld[0], st0);
            chk(la[1], sp0 - 32'h8);
            chk(ld[1], pc0);
            chk(la[2], va);
            chk(nsp, sp0 - 32'h8);
            chk(sw, (st0 & ~32'hF0) | 32'({m, 4'h0}));
        end
    endtask

    task automatic wr_base;
        @(posedge sys_clk);
        base_wr <= 1;
        @(posedge sys_clk);
        base_wr <= 0;
    endtask

    task automatic t_resets;
        do_exc(SRC_POR, 32'h0, 1, 4'hF);
        @(posedge sys_clk);
        pin <= 0;
        repeat (20) @(posedge sys_clk);
        pin <= 1;
        do_exc(SRC_POR, 32'h0, 1, 4'hF);
        for (int k = 0; k < 2; k++) begin
            wr_base();
            wdog_man <= k[0];
            wdog_ovf <= 1;
            @(posedge sys_clk);
            wdog_ovf <= 0;
            do_exc(k[0] ? SRC_MR : SRC_POR, k[0] ? 32'h8 : 32'h0, 1, 4'hF);
        end
        $display("test resets done");
    endtask

    task automatic t_prio;
        ces_src_t srcs [6] = '{SRC_CAE, SRC_DAE, SRC_NMI, SRC_UBRK, SRC_IRQ, SRC_PER};
        logic [7:0] vecs [6] = '{VEC_CAE, VEC_DAE, VEC_NMI, VEC_UBRK, 8'h41, 8'h50};
        logic [3:0] msks [6] = '{4'h7, 4'h7, 4'hF, 4'hF, 4'h3, 4'h5};
        wr_base();
        slow <= 1;
        {cae, dae, nmi, ubrk, per, dv} <= 6'h3F;
        irq <= 4'h6;
        @(posedge sys_clk);
        {cae, dae, nmi, ubrk, per, dv} <= 6'h00;
        irq <= 4'h0;
        repeat (4) @(posedge sys_clk);
        #1;
        chk({30'h0, busy, taken}, 32'h0);
        for (int k = 0; k < 6; k++) begin
            @(posedge sys_clk);
            done <= 1;
            @(posedge sys_clk);
            done <= 0;
            do_exc(srcs[k], base_d + 32'({vecs[k], 2'b00}), 0, msks[k]);
        end
        slow <= 0;
        $display("test priority done");
    endtask

    task automatic t_trap;
        @(posedge sys_clk);
        trap <= 1;
        @(posedge sys_clk);
        trap <= 0;
        do_exc(SRC_TRAP, base_d + 32'h84, 0, 4'h7);
        $display("test trap done");
    endtask

    // Second class lands in the slot of the first when the first is delayed
    task automatic t_slots;
        ces_cls_t c;
        logic dly;
        for (int k = 1; k < 14; k++) begin
            for (int j = 0; j < 2; j++) begin
                c = ces_cls_t'(k[3:0]);
                dly = j == 0 || !(c inside {CLS_BT, CLS_BF, CLS_TRAP});
                @(posedge sys_clk);
                dv <= 1;
                cls <= j == 0 ? CLS_JMP : c;
                @(posedge sys_clk);
                cls <= j == 0 ? c : CLS_UNDEF;
                @(posedge sys_clk);
                dv <= 0;
                cls <= CLS_PLAIN;
                do_exc(dly ? SRC_SILL : SRC_GILL, base_d + (dly ? 32'h18 : 32'h10), 0, 4'h7);
            end
        end
        $display("test slots done");
    endtask

    initial begin
        repeat (3) @(posedge sys_clk);
        rst_b <= 1;
        t_resets();
        t_prio();
        t_trap();
        t_slots();
        end_sim();
    end
endmodule
